// file: rtl/mic_map.svh
// constants for the medium interface control block
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH
`define MIC_RCS_IDLE        3'h0
`define MIC_TCS_IDLE        3'h0
`define MIC_TYPE_RESET      4'hF
`define MIC_SKEW_RESET      16'h0000
`define MIC_SKEW_MAX        16'hFFFF
`define MIC_SYS_CLK_KHZ     25000
`define MIC_TX_CLK_KHZ      30000
// divider half period in sys cycles; 25 MHz cannot reach 30 MHz, so the
// nearest achievable rate (sys/2) is used and the figure kept for reference
`define MIC_TX_HALF_CYCLES  (((`MIC_SYS_CLK_KHZ) / (2 * (`MIC_TX_CLK_KHZ))) + 1)
`endif

// file: rtl/mic_pkg.sv
// types shared by the medium interface control block
package mic_pkg;
  typedef enum logic [1:0] {MIC_SX_BEGIN, MIC_SX_MORE, MIC_SX_END2, MIC_SX_END4} mic_sx_status_t;
  typedef enum logic {MIC_TXS_VALID, MIC_TXS_MARKER} mic_tx_status_t;
  typedef enum logic {MIC_PRI_NORMAL, MIC_PRI_HIGH} mic_pri_t;
  typedef enum logic {MIC_DONE_MORE, MIC_DONE_END} mic_done_t;
endpackage : mic_pkg

// file: rtl/mic_sync.sv
// two-flop level synchroniser, parameterised width
`timescale 1ns/10ps
module mic_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : mic_sync

// file: rtl/mic_rx_lane.sv
// per-channel start delimiter capture on the recovered clock
`timescale 1ns/10ps
module mic_rx_lane (
  // recovered clock domain
  input  wire logic rx_clk_in,
  input  wire logic rx_rst_n_in,
  // delimiter indications from the lane decoder
  input  wire logic new_packet_in,
  input  wire logic high_start_in,
  input  wire logic normal_start_in,
  input  wire logic bad_start_in,
  // sticky per-lane flags
  output logic      high_seen_out,
  output logic      normal_seen_out,
  output logic      bad_seen_out
);
  // sticky until a new packet; a detect in the clear cycle still wins
  always_ff @(posedge rx_clk_in)
  begin
    if (!rx_rst_n_in)
    begin
      high_seen_out   <= 1'b0;
      normal_seen_out <= 1'b0;
      bad_seen_out    <= 1'b0;
    end
    else
    begin
      high_seen_out   <= high_start_in | (high_seen_out & ~new_packet_in);
      normal_seen_out <= normal_start_in | (normal_seen_out & ~new_packet_in);
      bad_seen_out    <= bad_start_in | (bad_seen_out & ~new_packet_in);
    end
  end
endmodule : mic_rx_lane

// file: rtl/mic_ctrl.sv
// host-side medium interface control: gates, delimiters, skew, errors
`timescale 1ns/10ps
`include "mic_map.svh"
// Behaviour
// - reception ends on gate release or idle receive state
// - completion reported cycle after transmit gate release
// - high flag needs high start on all lanes
// - normal flag needs normal start on all lanes
// - count cycles with partial start detection
// - frame error on bad start, code, weight
// - encoder sextet status begin, more, end
// - done only after end marker and fill
// - generator takes frame status and priority
// - detector idles unless run asserted
// - generator idles unless run asserted
// - both gates disabled unless requested
// - recovered clock rise as one event
// - drive three-bit transmit control state
// - transmit lanes carry data only when gated
// - host sources transmit clock and gates
// - host supplies the transmit clock
// - transmit gate is active low
// - receive gate is active low
module mic_ctrl
  import mic_pkg::*;
#(
  parameter int LANES      = 4,
  parameter int SKEW_WIDTH = 16
) (
  // system clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_n_in,
  // recovered clock domain
  input  wire logic                   recovered_clock_in,
  input  wire logic                   rx_rst_n_in,
  input  wire logic [LANES-1:0]       rx_data_in,
  input  wire logic [LANES-1:0]       lane_high_start_in,
  input  wire logic [LANES-1:0]       lane_normal_start_in,
  input  wire logic [LANES-1:0]       lane_bad_start_in,
  input  wire logic                   rx_code_error_in,
  input  wire logic                   rx_weight_error_in,
  // medium sublayer pins
  input  wire logic                   grant_indication_in,
  input  wire logic [2:0]             receive_control_state_in,
  input  wire logic [3:0]             medium_type_in,
  output logic                        transmit_clock_out,
  output logic                        transmit_gate_n_out,
  output logic                        receive_gate_n_out,
  output logic [2:0]                  transmit_control_state_out,
  output logic [LANES-1:0]            tx_data_out,
  // host control
  input  wire logic                   tx_request_in,
  input  wire logic                   rx_request_in,
  input  wire logic                   run_detector_in,
  input  wire logic                   run_generator_in,
  input  wire logic [2:0]             tcs_request_in,
  input  wire logic [LANES-1:0]       sextet_lanes_in,
  input  wire mic_pkg::mic_sx_status_t sextet_status_in,
  input  wire mic_pkg::mic_tx_status_t frame_status_in,
  input  wire mic_pkg::mic_pri_t      frame_priority_in,
  // host status
  output logic                        grant_out,
  output logic [2:0]                  rcs_out,
  output logic [3:0]                  medium_type_out,
  output logic                        rx_end_out,
  output logic                        recovered_clock_rise_out,
  output logic                        high_start_all_lanes_out,
  output logic                        normal_start_all_lanes_out,
  output mic_pkg::mic_pri_t           rx_priority_out,
  output logic                        rx_error_out,
  output logic [SKEW_WIDTH-1:0]       skew_out,
  output logic [LANES-1:0]            rx_lanes_out,
  output logic                        tx_done_out,
  output mic_pkg::mic_done_t          transmit_complete_out,
  output logic                        marker_sent_out,
  output mic_pkg::mic_pri_t           tx_priority_out
);
  import mic_pkg::*;

  // ----------------------------------------------------------------
  // transmit clock divider
  // ----------------------------------------------------------------
  localparam int HALF = `MIC_TX_HALF_CYCLES;
  logic [7:0] div_cnt;
  logic       tx_tick;

  // the transmit clock is ours; tick marks its rising edge in sys time
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt            <= 8'h00;
      transmit_clock_out <= 1'b0;
    end
    else if (div_cnt == 8'(HALF - 1))
    begin
      div_cnt            <= 8'h00;
      transmit_clock_out <= ~transmit_clock_out;
    end
    else
    begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign tx_tick = (div_cnt == 8'(HALF - 1)) & ~transmit_clock_out;

  // ----------------------------------------------------------------
  // pins from the medium, resynchronised
  // ----------------------------------------------------------------
  logic [7:0] pin_sync;
  mic_sync #(.WIDTH(8)) u_pin_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .d_in     ({grant_indication_in, receive_control_state_in, medium_type_in}),
    .q_out    (pin_sync)
  );

  // grant, receive state and type code are the medium's to drive
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      grant_out       <= 1'b0;
      rcs_out         <= `MIC_RCS_IDLE;
      medium_type_out <= `MIC_TYPE_RESET;
    end
    else
    begin
      grant_out       <= pin_sync[7];
      rcs_out         <= pin_sync[6:4];
      medium_type_out <= pin_sync[3:0];
    end
  end

  // ----------------------------------------------------------------
  // gates and transmit control state, updated on transmit clock rise
  // ----------------------------------------------------------------
  logic tx_gate_on;
  logic tx_gate_was;

  // gates default to off; only an explicit request turns one on
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      transmit_gate_n_out        <= 1'b1;
      receive_gate_n_out         <= 1'b1;
      transmit_control_state_out <= `MIC_TCS_IDLE;
    end
    else if (tx_tick)
    begin
      transmit_gate_n_out        <= ~tx_request_in;
      receive_gate_n_out         <= ~rx_request_in;
      transmit_control_state_out <= tcs_request_in;
    end
  end
  assign tx_gate_on = ~transmit_gate_n_out;

  // ----------------------------------------------------------------
  // delimiter generator
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MIC_GEN_IDLE, MIC_GEN_DATA, MIC_GEN_FILL, MIC_GEN_DONE} mic_gen_t;
  mic_gen_t gen_state;

  // runs only while enabled; fill follows the last sextet before done
  // lanes follow the request the gate loads on this tick, so they never trail the gate
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !run_generator_in)
    begin
      gen_state       <= MIC_GEN_IDLE;
      tx_data_out     <= '0;
      tx_done_out     <= 1'b0;
      marker_sent_out <= 1'b0;
      tx_priority_out <= MIC_PRI_NORMAL;
    end
    else if (tx_tick)
    begin
      case (gen_state)
        MIC_GEN_IDLE:
        begin
          tx_done_out <= 1'b0;
          tx_data_out <= '0;
          if (tx_request_in && sextet_status_in == MIC_SX_BEGIN)
          begin
            tx_priority_out <= frame_priority_in;
            marker_sent_out <= (frame_status_in == MIC_TXS_MARKER);
            tx_data_out     <= sextet_lanes_in;
            gen_state       <= MIC_GEN_DATA;
          end
        end
        MIC_GEN_DATA:
        begin
          tx_data_out <= tx_request_in ? sextet_lanes_in : '0;
          if (sextet_status_in == MIC_SX_END2 || sextet_status_in == MIC_SX_END4)
          begin
            gen_state <= MIC_GEN_FILL;
          end
        end
        MIC_GEN_FILL:
        begin
          tx_data_out <= '0;
          gen_state   <= MIC_GEN_DONE;
        end
        MIC_GEN_DONE:
        begin
          tx_done_out <= 1'b1;
          if (!tx_gate_on)
          begin
            gen_state <= MIC_GEN_IDLE;
          end
        end
        default:
        begin
          gen_state <= MIC_GEN_IDLE;
        end
      endcase
    end
  end

  // completion is reported one transmit clock after the gate drops
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      tx_gate_was           <= 1'b0;
      transmit_complete_out <= MIC_DONE_MORE;
    end
    else if (tx_tick)
    begin
      tx_gate_was <= tx_gate_on;
      if (tx_gate_was && !tx_gate_on)
      begin
        transmit_complete_out <= MIC_DONE_END;
      end
      else if (tx_gate_on)
      begin
        transmit_complete_out <= MIC_DONE_MORE;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive side on the recovered clock
  // ----------------------------------------------------------------
  logic [LANES-1:0] hi_seen;
  logic [LANES-1:0] no_seen;
  logic [LANES-1:0] bad_seen;
  logic             rx_run_rx;
  logic             rx_run_meta;
  logic             rx_run_prev;
  logic             new_packet;
  logic [LANES-1:0] rx_lanes_rx;

  // detector run level crosses into the recovered domain
  always_ff @(posedge recovered_clock_in)
  begin
    if (!rx_rst_n_in)
    begin
      rx_run_meta <= 1'b0;
      rx_run_rx   <= 1'b0;
      rx_run_prev <= 1'b0;
      rx_lanes_rx <= '0;
    end
    else
    begin
      rx_run_meta <= run_detector_in & ~receive_gate_n_out;
      rx_run_rx   <= rx_run_meta;
      rx_run_prev <= rx_run_rx;
      rx_lanes_rx <= rx_data_in;
    end
  end
  // the clock may stop between frames, so a packet starts on run rise
  assign new_packet = rx_run_rx & ~rx_run_prev;

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      mic_rx_lane u_lane (
        .rx_clk_in       (recovered_clock_in),
        .rx_rst_n_in     (rx_rst_n_in),
        .new_packet_in   (new_packet),
        .high_start_in   (rx_run_rx & lane_high_start_in[g]),
        .normal_start_in (rx_run_rx & lane_normal_start_in[g]),
        .bad_start_in    (rx_run_rx & lane_bad_start_in[g]),
        .high_seen_out   (hi_seen[g]),
        .normal_seen_out (no_seen[g]),
        .bad_seen_out    (bad_seen[g])
      );
    end
  endgenerate

  logic [LANES-1:0] any_seen;
  logic [SKEW_WIDTH-1:0] skew_rx;
  logic             err_rx;
  assign any_seen = hi_seen | no_seen;

  // skew counts partial-detect cycles and saturates instead of wrapping
  always_ff @(posedge recovered_clock_in)
  begin
    if (!rx_rst_n_in || new_packet)
    begin
      skew_rx <= '0;
      // an error event in the clear cycle still belongs to the new packet
      err_rx  <= rx_rst_n_in & (rx_code_error_in | rx_weight_error_in);
    end
    else if (rx_run_rx)
    begin
      if ((|any_seen) && !(&any_seen) && skew_rx != '1)
      begin
        skew_rx <= skew_rx + 1'b1;
      end
      if ((|bad_seen) || rx_code_error_in || rx_weight_error_in)
      begin
        err_rx <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // status back into the system domain
  // ----------------------------------------------------------------
  // flags are sticky for the packet, so level sync is enough; the
  // skew word is only trustworthy once it stops changing
  logic [LANES*3+SKEW_WIDTH:0] st_sync;
  mic_sync #(.WIDTH(LANES*3+SKEW_WIDTH+1)) u_st_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .d_in     ({hi_seen, no_seen, rx_lanes_rx, skew_rx, err_rx}),
    .q_out    (st_sync)
  );

  logic rise_meta;
  logic rise_sync;
  logic rise_prev;
  mic_sync #(.WIDTH(1)) u_clk_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .d_in     (recovered_clock_in),
    .q_out    (rise_meta)
  );

  // edge detect after synchroniser, one pulse per rise
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      rise_sync                  <= 1'b0;
      rise_prev                  <= 1'b0;
      recovered_clock_rise_out   <= 1'b0;
      high_start_all_lanes_out   <= 1'b0;
      normal_start_all_lanes_out <= 1'b0;
      rx_priority_out            <= MIC_PRI_NORMAL;
      rx_error_out               <= 1'b0;
      skew_out                   <= '0;
      rx_lanes_out               <= '0;
      rx_end_out                 <= 1'b1;
    end
    else
    begin
      rise_sync                  <= rise_meta;
      rise_prev                  <= rise_sync;
      recovered_clock_rise_out   <= rise_sync & ~rise_prev;
      high_start_all_lanes_out   <= &st_sync[LANES*3+SKEW_WIDTH -: LANES];
      normal_start_all_lanes_out <= &st_sync[LANES*2+SKEW_WIDTH -: LANES];
      rx_priority_out <= (&st_sync[LANES*3+SKEW_WIDTH -: LANES]) ? MIC_PRI_HIGH : MIC_PRI_NORMAL;
      rx_error_out               <= st_sync[0];
      skew_out                   <= st_sync[SKEW_WIDTH:1];
      rx_lanes_out               <= st_sync[LANES+SKEW_WIDTH -: LANES];
      rx_end_out <= receive_gate_n_out | (rcs_out == `MIC_RCS_IDLE);
    end
  end
endmodule : mic_ctrl

// file: testbench/mic_ctrl_properties.sv
// concurrent checks on the ports of the medium interface control block
`timescale 1ns/10ps
module mic_ctrl_properties
  import mic_pkg::*;
#(
  parameter int LANES = 4
) (
  // clock and reset
  input wire logic               clk_sys_in,
  input wire logic               rst_n_in,
  // host control
  input wire logic               tx_request_in,
  input wire logic               rx_request_in,
  input wire logic               run_generator_in,
  // watched outputs
  input wire logic               transmit_gate_n_out,
  input wire logic               receive_gate_n_out,
  input wire logic [LANES-1:0]   tx_data_out,
  input wire logic               rx_end_out,
  input wire logic [2:0]         rcs_out,
  input wire logic               recovered_clock_rise_out,
  input wire logic               tx_done_out,
  input wire logic               marker_sent_out,
  input wire mic_pkg::mic_done_t transmit_complete_out
);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // four quiet cycles always span one tick plus the gate register
  sequence s_tx_quiet; !tx_request_in [*4]; endsequence
  sequence s_rx_quiet; !rx_request_in [*4]; endsequence
  property p_tx_gate_off; s_tx_quiet |-> transmit_gate_n_out; endproperty
  property p_rx_gate_off; s_rx_quiet |-> receive_gate_n_out; endproperty
  property p_tx_lanes_quiet;
    transmit_gate_n_out && $past(transmit_gate_n_out) |-> tx_data_out == '0;
  endproperty
  property p_end_on_gate; receive_gate_n_out [*2] |-> rx_end_out; endproperty
  property p_end_on_idle; (rcs_out == 3'h0) [*2] |-> rx_end_out; endproperty
  property p_rise_single; recovered_clock_rise_out |=> !recovered_clock_rise_out; endproperty
  property p_complete_late;
    $rose(transmit_complete_out == MIC_DONE_END) |->
      transmit_gate_n_out && $past(transmit_gate_n_out);
  endproperty
  property p_gen_idle;
    !run_generator_in [*2] |-> !tx_done_out && !marker_sent_out;
  endproperty
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_tx_gate_off: assert property (p_tx_gate_off)
    else $error("transmit gate on without request");
  a_rx_gate_off: assert property (p_rx_gate_off)
    else $error("receive gate on without request");
  a_tx_lanes_quiet: assert property (p_tx_lanes_quiet)
    else $error("transmit lanes busy while gate off");
  a_end_on_gate: assert property (p_end_on_gate)
    else $error("reception not ended with gate off");
  a_end_on_idle: assert property (p_end_on_idle)
    else $error("reception not ended on idle receive state");
  a_rise_single: assert property (p_rise_single)
    else $error("clock rise event longer than one cycle");
  a_complete_late: assert property (p_complete_late)
    else $error("completion before transmit gate release");
  a_gen_idle: assert property (p_gen_idle)
    else $error("generator active while not running");
endmodule : mic_ctrl_properties

bind mic_ctrl mic_ctrl_properties #(.LANES(LANES)) i_mic_ctrl_properties (
  .clk_sys_in, .rst_n_in, .tx_request_in, .rx_request_in, .run_generator_in,
  .transmit_gate_n_out, .receive_gate_n_out, .tx_data_out, .rx_end_out, .rcs_out,
  .recovered_clock_rise_out, .tx_done_out, .marker_sent_out, .transmit_complete_out);

// file: testbench/mic_medium_model.sv
// behavioural medium sublayer: recovered clock, receive lanes, delimiter pulses
`timescale 1ns/10ps
module mic_medium_model (
  // from the host side
  input  wire logic rx_gate_n_in,
  input  wire logic rx_rst_n_in,
  // toward the host side
  output logic       rclk_out,
  output logic [3:0] rdata_out,
  output logic [3:0] high_out,
  output logic [3:0] normal_out,
  output logic [3:0] bad_out,
  output logic       code_err_out,
  output logic       weight_err_out
);
  // ----------------------------------------
  // recovered clock, held low while the receive gate is off
  // ----------------------------------------
  // also runs during rx reset so that reset sees edges of its own clock
  initial
  begin
    rclk_out = 1'b0;
    #7;
    forever
    begin
      #40;
      rclk_out = (rx_gate_n_in && rx_rst_n_in) ? 1'b0 : ~rclk_out;
    end
  end
  // lanes move on rises only; flipped when released so no stale value shows
  initial rdata_out = 4'h0;
  always @(posedge rclk_out) rdata_out <= rdata_out + 4'h3;
  always @(posedge rx_gate_n_in) rdata_out <= ~rdata_out;
  initial {high_out, normal_out, bad_out, code_err_out, weight_err_out} = 14'h0000;
  // one-cycle delimiter indications on the recovered clock
  task automatic pulse(input logic [3:0] hi, nm, bd, input logic ce, we);
    @(posedge rclk_out);
    {high_out, normal_out, bad_out, code_err_out, weight_err_out} <= {hi, nm, bd, ce, we};
    @(posedge rclk_out);
    {high_out, normal_out, bad_out, code_err_out, weight_err_out} <= 14'h0000;
  endtask : pulse
endmodule : mic_medium_model

// file: testbench/test_mic_ctrl.sv
// self-checking bench for the medium interface control block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module test_mic_ctrl;
  import mic_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rrst_n = 1'b0, rclk, cerr, werr, grant, grant_o;
  logic tx_req, rx_req, run_det, run_gen, tclk, txg_n, rxg_n, rx_end, rise;
  logic hi_all, no_all, rx_err, tx_done, marker;
  logic [2:0] tcs_req, tcs_o, rcs, rcs_o;
  logic [3:0] rdata, hi, nm, bad, mtype, mtype_o, sextet, tdata, rlanes, r0;
  logic [15:0] skew, s0;
  mic_sx_status_t sx;
  mic_tx_status_t fst;
  mic_pri_t fpri, rx_pri, tx_pri;
  mic_done_t tcomp;
  int fail_count = 0, n_compared = 0, rises = 0;
  // ----------------------------------------
  // design, far side, clock
  // ----------------------------------------
  mic_ctrl i_mic_ctrl (.clk_sys_in(clk), .rst_n_in(rst_n), .recovered_clock_in(rclk),
    .rx_rst_n_in(rrst_n), .rx_data_in(rdata), .lane_high_start_in(hi),
    .lane_normal_start_in(nm), .lane_bad_start_in(bad), .rx_code_error_in(cerr),
    .rx_weight_error_in(werr), .grant_indication_in(grant), .receive_control_state_in(rcs),
    .medium_type_in(mtype), .transmit_clock_out(tclk), .transmit_gate_n_out(txg_n),
    .receive_gate_n_out(rxg_n), .transmit_control_state_out(tcs_o), .tx_data_out(tdata),
    .tx_request_in(tx_req), .rx_request_in(rx_req), .run_detector_in(run_det),
    .run_generator_in(run_gen), .tcs_request_in(tcs_req), .sextet_lanes_in(sextet),
    .sextet_status_in(sx), .frame_status_in(fst), .frame_priority_in(fpri),
    .grant_out(grant_o), .rcs_out(rcs_o), .medium_type_out(mtype_o), .rx_end_out(rx_end),
    .recovered_clock_rise_out(rise), .high_start_all_lanes_out(hi_all),
    .normal_start_all_lanes_out(no_all), .rx_priority_out(rx_pri), .rx_error_out(rx_err),
    .skew_out(skew), .rx_lanes_out(rlanes), .tx_done_out(tx_done),
    .transmit_complete_out(tcomp), .marker_sent_out(marker), .tx_priority_out(tx_pri));
  mic_medium_model i_mic_medium_model (.rx_gate_n_in(rxg_n), .rx_rst_n_in(rrst_n),
    .rclk_out(rclk), .rdata_out(rdata), .high_out(hi), .normal_out(nm), .bad_out(bad),
    .code_err_out(cerr), .weight_err_out(werr));
  always #20 clk = ~clk;
  always @(posedge clk) if (rise === 1'b1) rises <= rises + 1;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // one frame: begin held two ticks, then more, then the last sextet
  task automatic tx_frame(input mic_tx_status_t st, mic_pri_t pr, mic_sx_status_t last);
    if (tclk !== 1'b0) cyc(1);
    tx_req = 1'b1;
    fst = st;
    fpri = pr;
    sx = MIC_SX_BEGIN;
    sextet = 4'h5;
    cyc(4);
    sx = MIC_SX_MORE;
    sextet = 4'hA;
    cyc(2);
    `CHK(tdata, 4'hA)
    sx = last;
    cyc(2);
    for (int i = 0; i < 40 && tx_done !== 1'b1; i++) cyc(1);
    `CHK(tx_done, 1'b1)
    `CHK(tdata, 4'h0)
    `CHK(tcomp, MIC_DONE_MORE)
    `CHK(marker, st == MIC_TXS_MARKER)
    `CHK(tx_pri, pr)
    `CHK(tcs_o, tcs_req)
    tx_req = 1'b0;
    for (int i = 0; i < 8 && txg_n !== 1'b1; i++) cyc(1);
    for (int i = 0; i < 5 && tcomp !== MIC_DONE_END; i++) cyc(1);
    `CHK(tcomp, MIC_DONE_END)
    cyc(4);
  endtask : tx_frame
  // new packet by a run rise, then two delimiter steps on the lanes
  task automatic rx_packet(input logic [3:0] h1, n1, b1, h2, n2, input logic ce, we, det,
                           input logic e_h, e_n, e_err, e_skew);
    run_det = 1'b0;
    cyc(8);
    run_det = det;
    cyc(12);
    i_mic_medium_model.pulse(h1, n1, b1, ce, we);
    i_mic_medium_model.pulse(h2, n2, 4'h0, 1'b0, 1'b0);
    cyc(16);
    `CHK(hi_all, e_h)
    `CHK(no_all, e_n)
    `CHK(rx_err, e_err)
    `CHK(skew != 16'h0000, e_skew)
  endtask : rx_packet
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {tx_req, rx_req, run_det, run_gen, grant, tcs_req, rcs} = {5'h01, 3'h6, 3'h0};
    {mtype, sextet} = {4'h9, 4'h0};
    sx = MIC_SX_BEGIN;
    fst = MIC_TXS_VALID;
    fpri = MIC_PRI_NORMAL;
    cyc(5);
    `CHK({txg_n, rxg_n, mtype_o}, 6'h3F)
    cyc(1);
    rst_n = 1'b1;
    cyc(4);
    rrst_n = 1'b1;
    cyc(6);
    `CHK({txg_n, rxg_n, rx_end, tdata}, 7'h70)
    `CHK({grant_o, rcs_o, mtype_o}, 8'h89)
    // the divided transmit clock flips on every system clock rise
    s0[0] = tclk;
    cyc(1);
    `CHK(tclk, ~s0[0])
    $display("test reset done");
    run_gen = 1'b1;
    tx_frame(MIC_TXS_MARKER, MIC_PRI_HIGH, MIC_SX_END4);
    tx_frame(MIC_TXS_VALID, MIC_PRI_NORMAL, MIC_SX_END2);
    // with the generator held idle a request must never finish
    {run_gen, tx_req} = 2'b01;
    cyc(30);
    `CHK(tx_done, 1'b0)
    tx_req = 1'b0;
    cyc(6);
    $display("test transmit done");
    {rx_req, rcs, grant} = {1'b1, 3'h3, 1'b0};
    for (int i = 0; i < 8 && rxg_n !== 1'b0; i++) cyc(1);
    cyc(8);
    `CHK(rx_end, 1'b0)
    `CHK({grant_o, rcs_o}, 4'h3)
    rises = 0;
    cyc(40);
    `CHK(rises >= 19 && rises <= 21, 1'b1)
    // lanes step on every recovered rise, so they must move within three cycles
    r0 = rlanes;
    cyc(3);
    `CHK(rlanes != r0, 1'b1)
    rx_packet(4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 0, 0, 1, 1, 0, 0, 0);
    `CHK(rx_pri, MIC_PRI_HIGH)
    rx_packet(4'h0, 4'h3, 4'h0, 4'h0, 4'hC, 0, 0, 1, 0, 1, 0, 1);
    `CHK(rx_pri, MIC_PRI_NORMAL)
    s0 = skew;
    cyc(10);
    `CHK(skew, s0)
    rx_packet(4'h7, 4'h0, 4'h8, 4'h0, 4'h0, 0, 0, 1, 0, 0, 1, 1);
    rx_packet(4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 1, 0, 1, 1, 0, 1, 0);
    rx_packet(4'h0, 4'hF, 4'h0, 4'h0, 4'h0, 0, 1, 1, 0, 1, 1, 0);
    rx_packet(4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 0, 0, 0, 0, 1, 1, 0);
    rcs = 3'h0;
    cyc(10);
    `CHK(rx_end, 1'b1)
    rx_req = 1'b0;
    cyc(10);
    `CHK({rxg_n, rx_end}, 2'h3)
    // with the gate off the recovered clock stops and the lanes hold
    r0 = rlanes;
    cyc(4);
    `CHK(rlanes, r0)
    $display("test receive done");
    test_done();
  end
  // watchdog sized well above the few hundred cycles the tests take
  initial
  begin
    #400000;
    fail_count++;
    test_done();
  end
endmodule : test_mic_ctrl
